/* File: rtl/vpw_defines.svh */
/*
 * Constants of the VPW protocol handler: register offsets, control bit
 * positions, reset values, symbol timing and CRC constants.
 * Assumes a 100 MHz system clock.
 */
`ifndef VPW_DEFINES_SVH
`define VPW_DEFINES_SVH

// register byte offsets
`define VPW_ADDR_DATA 4'h0
`define VPW_ADDR_SVR 4'h4
`define VPW_ADDR_CR1 4'h8
`define VPW_ADDR_CR2 4'hc

// control bit positions and reset values
`define VPW_CR1_IRQ_EN 0
`define VPW_CR2_LOOP 0
`define VPW_CR2_FAST 1
`define VPW_CR1_RST 8'h00
`define VPW_CR2_RST 8'h00

// clock rates
`define VPW_CLK_MHZ 100
`define VPW_CLK_NS 10
`define VPW_MOD_CLK_NS 1000

// receive window bounds in microseconds
`define VPW_BIT_MIN_US 34
`define VPW_ZO_US 96
`define VPW_SOF_MIN_US 163
`define VPW_BRK_US 240
`define VPW_EOF_US 280
`define VPW_IDLE_US 300

// transmit nominal lengths in microseconds
`define VPW_SHORT_US 64
`define VPW_LONG_US 128
`define VPW_SOF_US 200

// late join limit in module clock periods
`define VPW_ARB_LATE_MOD 104

// echo delay allowed before a mismatch counts
`define VPW_LAG_CYC 4

// crc-8
`define VPW_CRC_POLY 8'h1d
`define VPW_CRC_INIT 8'hff
`define VPW_CRC_RESIDUE 8'hc4

`endif

/* File: rtl/vpw_pkg.sv */
/*
 * Types of the VPW protocol handler: symbol classes, transmitter states
 * and the status register layout.
 * Assumes nothing of its surroundings.
 */
package vpw_pkg;

    typedef enum logic [2:0] {
        SYM_BAD = 3'b000,
        SYM_ONE = 3'b001,
        SYM_ZERO = 3'b010,
        SYM_SOF = 3'b011,
        SYM_BRK = 3'b100,
        SYM_EOD = 3'b101
    } vpw_sym_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_SOF = 3'b001,
        TX_DATA = 3'b010,
        TX_EOD = 3'b011,
        TX_RESYNC = 3'b100,
        TX_EXTRA = 3'b101
    } vpw_tx_state_t;

    typedef struct packed {
        logic bus_idle;
        logic eof;
        logic arb_lost;
        logic invalid;
        logic crc_err;
        logic tx_empty;
        logic rx_resp;
        logic rx_full;
    } vpw_status_t;

endpackage : vpw_pkg

/* File: rtl/vpw_protocol_handler.sv */
/*
 * VPW single-wire protocol handler: symbol timing, framing, CRC,
 * bitwise arbitration, shadow registers, loopback and error flags.
 * Assumes a classic Wishbone master on clk and an asynchronous bus
 * receive line from a transceiver; tx_line_out high drives active.
 */
// Operation
// - active end in shortest valid window decodes as logic one
// - active end in next window decodes as logic zero
// - active end in window above zero is start of frame
// - active past longest frame start is break; never sent
// - pending send waits for idle bus if message in progress
// - arbitration starts at first bit after frame start
// - data write within 104 module clocks of edge joins, else waits
// - logic zero dominates one; lowest value wins
// - recessive sent, dominant seen: lose and release bus at once
// - loss on eighth bit: append up to two arbitrated ones
// - full byte goes to receive shadow, sets flag, may interrupt
// - finished shift loads from shadow, shows transmit empty
// - receive path from own output or bus line per loopback bit
// - never send fast rate; receive it only when enabled
// - no limit on message length
// - own message error stops sending, flags, may interrupt
// - crc mismatch after data and check byte sets crc flag
// - end of data off byte boundary or active during own end errs
// - bus held active: no send until passive
// - bus stuck passive: send fails, abort, wait for new command
// - break in a frame or during own send flags invalid symbol, cleared by read; wait idle
// - zero is 64 us passive or 128 us active
// - one is 128 us passive or 64 us active
// - frame start is 200 us active
// - break is at least 240 us active
`timescale 1ns/100ps
`default_nettype none
`include "vpw_defines.svh"

module vpw_protocol_handler
    import vpw_pkg::*;
#(
    parameter logic [17:0] T_BIT_MIN = 18'(`VPW_BIT_MIN_US * `VPW_CLK_MHZ),
    parameter logic [17:0] T_ZO = 18'(`VPW_ZO_US * `VPW_CLK_MHZ),
    parameter logic [17:0] T_SOF_MIN = 18'(`VPW_SOF_MIN_US * `VPW_CLK_MHZ),
    parameter logic [17:0] T_BRK = 18'(`VPW_BRK_US * `VPW_CLK_MHZ),
    parameter logic [17:0] T_EOF = 18'(`VPW_EOF_US * `VPW_CLK_MHZ),
    parameter logic [17:0] T_IDLE = 18'(`VPW_IDLE_US * `VPW_CLK_MHZ),
    parameter logic [17:0] T_SHORT = 18'(`VPW_SHORT_US * `VPW_CLK_MHZ),
    parameter logic [17:0] T_LONG = 18'(`VPW_LONG_US * `VPW_CLK_MHZ),
    parameter logic [17:0] T_SOF = 18'(`VPW_SOF_US * `VPW_CLK_MHZ),
    parameter logic [17:0] T_ARB_LATE = 18'(`VPW_ARB_LATE_MOD * `VPW_MOD_CLK_NS / `VPW_CLK_NS)
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // bus transceiver
    input wire logic rx_line_in,
    output logic tx_line_out,
    // interrupt request
    output logic irq_o
);

    localparam logic [17:0] LAG = 18'(`VPW_LAG_CYC);

    function automatic vpw_sym_t classify(input logic act, input logic [17:0] t);
        vpw_sym_t s;
        s = SYM_BAD;
        if (t < T_BIT_MIN)
            s = SYM_BAD;
        else if (t < T_ZO)
            s = act ? SYM_ONE : SYM_ZERO;
        else if (t < T_SOF_MIN)
            s = act ? SYM_ZERO : SYM_ONE;
        else if (act)
            s = (t < T_BRK) ? SYM_SOF : SYM_BRK;
        else
            s = SYM_EOD;
        return s;
    endfunction : classify

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c;
        for (int i = 7; i >= 0; i--)
        begin
            r = (r[7] ^ d[i]) ? ({r[6:0], 1'b0} ^ `VPW_CRC_POLY) : {r[6:0], 1'b0};
        end
        return r;
    endfunction : crc8

    // control and cpu side
    logic [7:0] ctrl1_q;
    logic [7:0] ctrl2_q;
    logic [7:0] shadow_q;
    logic shadow_full_q;
    logic [7:0] rx_data_q;
    logic rx_full_q, rx_resp_q, crc_err_q, invalid_q, arb_lost_q, eof_q;
    logic ack_q, irq_q;
    logic [31:0] dat_q;
    // bus timing
    logic rx_meta_q, rx_sync_q, rx_lvl_q;
    logic [15:0] cnt_q;
    logic bus_idle_q, gap_q, frame_start_q, brk_done_q;
    // receiver
    logic in_frame_q, fast_q, wait_idle_q, eod_done_q, resp_q, nb_skip_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] rx_shift_q, rx_crc_q;
    // transmitter
    vpw_tx_state_t tx_state_q;
    logic tx_q, seen_match_q, prev_bit_q, prev_idx7_q, crc_sent_q;
    logic [15:0] tx_cnt_q;
    logic [2:0] tx_idx_q;
    logic [7:0] tx_shift_q, tx_crc_q;
    logic [1:0] extra_q;

    logic rx_src, rx_edge, fall, rise;
    logic [17:0] t_eff;
    vpw_sym_t sym;
    logic sof_norm, sof_fast, start_ev, bit_ev, bad_ev, resp_ev, eod_ev;
    logic byte_done, brk_ev, eof_ev, crc_ev, frm_ev, join_ok;
    logic [7:0] new_byte;
    logic tx_busy, cur_bit, mism, judge_bit, judge7, lose, err, bit_end;
    logic tx_start, tx_load, tx_abort;
    logic [17:0] dur;
    logic acc, wr, rd, rd_data, rd_svr;
    vpw_status_t status;

    // receive source and symbol decode
    always_comb
    begin
        rx_src = ctrl2_q[`VPW_CR2_LOOP] ? tx_q : rx_sync_q;
        rx_edge = rx_src ^ rx_lvl_q;
        fall = rx_edge & rx_lvl_q;
        rise = rx_edge & ~rx_lvl_q;
        t_eff = fast_q ? {cnt_q, 2'b00} : {2'b00, cnt_q};
        sym = classify(rx_lvl_q, t_eff);
        sof_norm = classify(1'b1, {2'b00, cnt_q}) == SYM_SOF;
        sof_fast = ctrl2_q[`VPW_CR2_FAST] & (classify(1'b1, {cnt_q, 2'b00}) == SYM_SOF);
        start_ev = fall & ~in_frame_q & ~wait_idle_q & (sof_norm | sof_fast);
        bit_ev = rx_edge & in_frame_q & ~eod_done_q & ~nb_skip_q & (sym == SYM_ONE | sym == SYM_ZERO);
        bad_ev = rx_edge & in_frame_q & ~eod_done_q & ~nb_skip_q & ~(sym == SYM_ONE | sym == SYM_ZERO);
        resp_ev = rise & in_frame_q & eod_done_q;
        eod_ev = in_frame_q & ~rx_lvl_q & ~rx_edge & ~eod_done_q & (t_eff >= T_SOF_MIN);
        new_byte = {rx_shift_q[6:0], sym == SYM_ONE};
        byte_done = bit_ev & (bit_cnt_q == 3'd7);
        crc_ev = eod_ev & (bit_cnt_q == 3'd0) & (rx_crc_q != `VPW_CRC_RESIDUE);
        frm_ev = eod_ev & (bit_cnt_q != 3'd0);
        brk_ev = rx_lvl_q & ~rx_edge & ~brk_done_q & (t_eff >= T_BRK);
        eof_ev = in_frame_q & ~rx_lvl_q & ~rx_edge & (t_eff >= T_EOF);
        join_ok = frame_start_q & rx_lvl_q & ({2'b00, cnt_q} <= T_ARB_LATE);
    end

    // synchroniser, edge timer and bus-level conditions
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rx_meta_q <= 1'b0;
            rx_sync_q <= 1'b0;
            rx_lvl_q <= 1'b0;
            cnt_q <= 16'h0000;
            bus_idle_q <= 1'b0;
            gap_q <= 1'b0;
            frame_start_q <= 1'b0;
            brk_done_q <= 1'b0;
        end
        else
        begin
            rx_meta_q <= rx_line_in;
            rx_sync_q <= rx_meta_q;
            rx_lvl_q <= rx_src;
            if (rx_edge)
            begin
                cnt_q <= 16'h0000;
                bus_idle_q <= 1'b0;
                gap_q <= 1'b0;
                brk_done_q <= 1'b0;
                frame_start_q <= rise & (gap_q | bus_idle_q);
            end
            else
            begin
                if (cnt_q != 16'hffff)
                    cnt_q <= cnt_q + 16'h0001;
                if (~rx_lvl_q & ({2'b00, cnt_q} >= T_IDLE))
                    bus_idle_q <= 1'b1;
                if (~rx_lvl_q & ({2'b00, cnt_q} >= T_EOF))
                    gap_q <= 1'b1;
                if (brk_ev)
                    brk_done_q <= 1'b1;
            end
        end
    end

    // receive framing, shift register and crc
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            in_frame_q <= 1'b0;
            fast_q <= 1'b0;
            wait_idle_q <= 1'b0;
            eod_done_q <= 1'b0;
            resp_q <= 1'b0;
            nb_skip_q <= 1'b0;
            bit_cnt_q <= 3'd0;
            rx_shift_q <= 8'h00;
            rx_crc_q <= `VPW_CRC_INIT;
        end
        else
        begin
            if (brk_ev)
                wait_idle_q <= 1'b1;
            else if (bus_idle_q)
                wait_idle_q <= 1'b0;
            if (start_ev)
            begin
                in_frame_q <= 1'b1;
                fast_q <= ~sof_norm;
                eod_done_q <= 1'b0;
                resp_q <= 1'b0;
                nb_skip_q <= 1'b0;
                bit_cnt_q <= 3'd0;
                rx_crc_q <= `VPW_CRC_INIT;
            end
            else if (brk_ev | bad_ev | eof_ev)
            begin
                in_frame_q <= 1'b0;
                fast_q <= 1'b0;
            end
            else if (bit_ev)
            begin
                rx_shift_q <= new_byte;
                bit_cnt_q <= bit_cnt_q + 3'd1;
                if (byte_done)
                    rx_crc_q <= crc8(rx_crc_q, new_byte);
            end
            else if (eod_ev)
                eod_done_q <= 1'b1;
            else if (resp_ev)
            begin
                eod_done_q <= 1'b0;
                resp_q <= 1'b1;
                nb_skip_q <= 1'b1;
                bit_cnt_q <= 3'd0;
                rx_crc_q <= `VPW_CRC_INIT;
            end
            else if (fall & nb_skip_q)
                nb_skip_q <= 1'b0;
        end
    end

    // transmit decisions
    always_comb
    begin
        tx_busy = tx_state_q != TX_IDLE;
        cur_bit = (tx_state_q == TX_EXTRA) | tx_shift_q[7];
        if (tx_state_q == TX_SOF || tx_state_q == TX_EOD)
            dur = T_SOF;
        else
            dur = (tx_q == cur_bit) ? T_SHORT : T_LONG;
        mism = tx_busy & (tx_state_q != TX_RESYNC) & (rx_src != tx_q) & ({2'b00, tx_cnt_q} >= LAG);
        judge_bit = seen_match_q ? cur_bit : prev_bit_q;
        judge7 = seen_match_q ? ((tx_state_q == TX_DATA) & (tx_idx_q == 3'd7)) : prev_idx7_q;
        lose = mism & ~tx_q & judge_bit & (tx_state_q != TX_SOF)
            & ~((tx_state_q == TX_EOD) & seen_match_q);
        err = mism & ~lose;
        bit_end = tx_busy & (tx_state_q != TX_RESYNC) & ~mism & ({2'b00, tx_cnt_q} >= dur - 18'd1);
        tx_start = ~tx_busy & shadow_full_q & ((bus_idle_q & ~rx_src) | join_ok);
        tx_load = tx_start | (bit_end & (tx_state_q == TX_DATA) & (tx_idx_q == 3'd7) & shadow_full_q);
        tx_abort = err | lose;
    end

    // transmit sequencer
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tx_state_q <= TX_IDLE;
            tx_q <= 1'b0;
            tx_cnt_q <= 16'h0000;
            tx_idx_q <= 3'd0;
            tx_shift_q <= 8'h00;
            tx_crc_q <= `VPW_CRC_INIT;
            crc_sent_q <= 1'b0;
            seen_match_q <= 1'b0;
            prev_bit_q <= 1'b0;
            prev_idx7_q <= 1'b0;
            extra_q <= 2'd0;
        end
        else if (!tx_busy)
        begin
            tx_q <= 1'b0;
            if (tx_start)
            begin
                tx_state_q <= TX_SOF;
                tx_q <= 1'b1;
                tx_cnt_q <= bus_idle_q ? 16'h0000 : cnt_q;
                tx_shift_q <= shadow_q;
                tx_crc_q <= crc8(`VPW_CRC_INIT, shadow_q);
                tx_idx_q <= 3'd0;
                crc_sent_q <= 1'b0;
                prev_bit_q <= 1'b0;
                prev_idx7_q <= 1'b0;
            end
        end
        else if (tx_state_q == TX_RESYNC)
        begin
            if (rx_edge)
            begin
                tx_state_q <= TX_EXTRA;
                tx_q <= rx_src;
                tx_cnt_q <= 16'h0000;
                seen_match_q <= 1'b1;
                extra_q <= 2'd2;
            end
            else if (bus_idle_q)
                tx_state_q <= TX_IDLE;
        end
        else
        begin
            if (tx_cnt_q != 16'hffff)
                tx_cnt_q <= tx_cnt_q + 16'h0001;
            if (rx_src == tx_q)
                seen_match_q <= 1'b1;
            if (mism)
            begin
                tx_q <= 1'b0;
                tx_state_q <= (lose & judge7) ? TX_RESYNC : TX_IDLE;
            end
            else if (bit_end)
            begin
                tx_q <= ~tx_q;
                tx_cnt_q <= 16'h0000;
                seen_match_q <= 1'b0;
                prev_bit_q <= cur_bit;
                prev_idx7_q <= (tx_state_q == TX_DATA) & (tx_idx_q == 3'd7);
                case (tx_state_q)
                    TX_SOF:
                    begin
                        tx_state_q <= TX_DATA;
                        prev_bit_q <= 1'b0;
                    end
                    TX_DATA:
                    begin
                        tx_idx_q <= tx_idx_q + 3'd1;
                        tx_shift_q <= {tx_shift_q[6:0], 1'b0};
                        if (tx_idx_q == 3'd7)
                        begin
                            if (shadow_full_q)
                            begin
                                tx_shift_q <= shadow_q;
                                tx_crc_q <= crc8(tx_crc_q, shadow_q);
                            end
                            else if (!crc_sent_q)
                            begin
                                tx_shift_q <= ~tx_crc_q;
                                crc_sent_q <= 1'b1;
                            end
                            else
                                tx_state_q <= TX_EOD;
                        end
                    end
                    TX_EXTRA:
                    begin
                        extra_q <= extra_q - 2'd1;
                        if (extra_q == 2'd1)
                        begin
                            tx_state_q <= TX_IDLE;
                            tx_q <= 1'b0;
                        end
                    end
                    default:
                    begin
                        tx_state_q <= TX_IDLE;
                        tx_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // wishbone access decode
    always_comb
    begin
        acc = wb_cyc_i & wb_stb_i & ~ack_q;
        wr = acc & wb_we_i & wb_sel_i[0];
        rd = acc & ~wb_we_i;
        rd_data = rd & (wb_adr_i == `VPW_ADDR_DATA);
        rd_svr = rd & (wb_adr_i == `VPW_ADDR_SVR);
        status.bus_idle = bus_idle_q;
        status.eof = eof_q;
        status.arb_lost = arb_lost_q;
        status.invalid = invalid_q;
        status.crc_err = crc_err_q;
        status.tx_empty = ~shadow_full_q;
        status.rx_resp = rx_resp_q;
        status.rx_full = rx_full_q;
    end

    // register file, shadow registers and flags
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
            ctrl1_q <= `VPW_CR1_RST;
            ctrl2_q <= `VPW_CR2_RST;
            shadow_q <= 8'h00;
            shadow_full_q <= 1'b0;
            rx_data_q <= 8'h00;
            rx_full_q <= 1'b0;
            rx_resp_q <= 1'b0;
            crc_err_q <= 1'b0;
            invalid_q <= 1'b0;
            arb_lost_q <= 1'b0;
            eof_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            ack_q <= acc;
            dat_q <= 32'h0000_0000;
            if (rd)
            begin
                if (wb_adr_i == `VPW_ADDR_DATA)
                    dat_q <= {24'h000000, rx_data_q};
                else if (wb_adr_i == `VPW_ADDR_SVR)
                    dat_q <= {24'h000000, status};
                else if (wb_adr_i == `VPW_ADDR_CR1)
                    dat_q <= {24'h000000, ctrl1_q};
                else if (wb_adr_i == `VPW_ADDR_CR2)
                    dat_q <= {24'h000000, ctrl2_q};
            end
            if (wr & (wb_adr_i == `VPW_ADDR_CR1))
                ctrl1_q <= wb_dat_i[7:0];
            if (wr & (wb_adr_i == `VPW_ADDR_CR2))
                ctrl2_q <= wb_dat_i[7:0];
            if (wr & (wb_adr_i == `VPW_ADDR_DATA))
            begin
                shadow_q <= wb_dat_i[7:0];
                shadow_full_q <= 1'b1;
            end
            else if (tx_load | tx_abort)
                shadow_full_q <= 1'b0;
            if (byte_done)
                rx_data_q <= new_byte;
            rx_full_q <= (byte_done & ~resp_q) | (rx_full_q & ~rd_data);
            rx_resp_q <= (byte_done & resp_q) | (rx_resp_q & ~rd_data);
            crc_err_q <= crc_ev | (crc_err_q & ~rd_svr);
            invalid_q <= bad_ev | frm_ev | err | (brk_ev & (in_frame_q | tx_busy))
                | (invalid_q & ~rd_svr);
            arb_lost_q <= lose | (arb_lost_q & ~rd_svr);
            eof_q <= eof_ev | (eof_q & ~rd_svr);
            irq_q <= ctrl1_q[`VPW_CR1_IRQ_EN] & (rx_full_q | rx_resp_q | crc_err_q
                | invalid_q | arb_lost_q | eof_q);
        end
    end

    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;
    assign tx_line_out = tx_q;
    assign irq_o = irq_q;

endmodule : vpw_protocol_handler
`default_nettype wire

/* File: testbench/vpw_protocol_handler_props.sv */
/* checker for the vpw handler ports.
   assumes binding into vpw_protocol_handler. */
`timescale 1ns/100ps
`default_nettype none
`include "vpw_defines.svh"
module vpw_protocol_handler_props
#(
    parameter logic [17:0] T_SHORT = 18'd6400,
    parameter logic [17:0] T_BRK = 18'd24000
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // line and interrupt
    input wire logic rx_line_in,
    input wire logic tx_line_out,
    input wire logic irq_o
);
    logic [17:0] tx_run_q;
    logic [17:0] rx_run_q;
    logic en_q;
    always_ff @(posedge clk)
        tx_run_q <= (rst || !tx_line_out) ? 18'h0 : tx_run_q + 18'h1;
    // bus held active by others while we are silent
    always_ff @(posedge clk)
        rx_run_q <= (rst || !rx_line_in || tx_line_out) ? 18'h0 : rx_run_q + {17'h0, ~&rx_run_q};
    always_ff @(posedge clk)
        if (rst)
            en_q <= 1'b0;
        else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == `VPW_ADDR_CR1 && wb_sel_i[0])
            en_q <= wb_dat_i[`VPW_CR1_IRQ_EN];
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    rd_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero");
    rd_upper_a: assert property (wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits set");
    no_break_a: assert property (tx_run_q < T_BRK)
        else $error("break sent");
    // a symbol ended by us while the line still followed us; aborts on a dead line are excluded
    no_fast_a: assert property ($fell(tx_line_out) && $past(rx_line_in) |-> tx_run_q >= T_SHORT - 18'h1)
        else $error("short active symbol sent");
    hold_off_a: assert property ($rose(tx_line_out) |-> rx_run_q < T_BRK)
        else $error("sent on stuck bus");
    irq_gate_a: assert property (irq_o |-> en_q || $past(en_q))
        else $error("irq while disabled");
    cover property ($rose(irq_o));
    cover property ($rose(tx_line_out));
    cover property (wb_ack_o && !wb_we_i);
endmodule : vpw_protocol_handler_props
bind vpw_protocol_handler vpw_protocol_handler_props #(.T_SHORT(T_SHORT), .T_BRK(T_BRK)) props_i (.clk, .rst,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .rx_line_in, .tx_line_out, .irq_o);
`default_nettype wire

/* File: testbench/vpw_node_model.sv */
/* far bus node: sends frames and breaks.
   assumes callers enter tasks just after a rising edge. */
`timescale 1ns/100ps
`default_nettype none
module vpw_node_model
#(
    parameter int T_SHORT = 64,
    parameter int T_LONG = 128,
    parameter int T_SOF = 200
)
(
    // clock
    input wire logic clk,
    // drive, 1 = active; released bus is pulled passive
    output var logic bus_act
);
    initial bus_act = 1'b0;
    // time divisor: 4 sends at the fast rate
    int sc = 1;
    task automatic hold(input logic lvl, input int n);
        bus_act <= lvl;
        repeat (n / sc) @(posedge clk);
    endtask : hold
    task automatic send2(input logic [15:0] w);
        logic act = 1'b0;
        hold(1'b1, T_SOF);
        for (int i = 15; i >= 0; i--)
        begin
            hold(act, (w[i] == act) ? T_SHORT : T_LONG);
            act = ~act;
        end
        hold(1'b0, 1);
    endtask : send2
    task automatic brk(input int n);
        hold(1'b1, T_SOF);
        hold(1'b0, T_SHORT);
        hold(1'b1, n);
        hold(1'b0, 1);
    endtask : brk
endmodule : vpw_node_model
`default_nettype wire

/* File: testbench/vpw_protocol_handler_test.sv */
/* self-checking bench for the vpw handler, scaled timing.
   assumes a wired bus of device and one far node. */
`timescale 1ns/100ps
`default_nettype none
`include "vpw_defines.svh"
module vpw_protocol_handler_test;
    logic clk, rst, cyc, stb, we, ack, tx, irq, sel0;
    logic [3:0] adr, sel;
    logic [31:0] wdat, rdat, r;
    logic [7:0] b, c;
    wire logic node_act;
    wire logic rx_line;
    int n_mismatch, checks_done, cycles, seed;
    assign rx_line = tx | node_act;
    vpw_node_model vpw_node_model_i (.clk(clk), .bus_act(node_act));
    // timing scaled to one clock per microsecond
    vpw_protocol_handler #(.T_BIT_MIN(18'(`VPW_BIT_MIN_US)), .T_ZO(18'(`VPW_ZO_US)),
        .T_SOF_MIN(18'(`VPW_SOF_MIN_US)), .T_BRK(18'(`VPW_BRK_US)), .T_EOF(18'(`VPW_EOF_US)),
        .T_IDLE(18'(`VPW_IDLE_US)), .T_SHORT(18'(`VPW_SHORT_US)), .T_LONG(18'(`VPW_LONG_US)),
        .T_SOF(18'(`VPW_SOF_US)), .T_ARB_LATE(18'(`VPW_ARB_LATE_MOD))) vpw_protocol_handler_i (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .rx_line_in(rx_line), .tx_line_out(tx), .irq_o(irq));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task conclude;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    task check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    function automatic logic [7:0] crc8(input logic [7:0] d);
        logic [7:0] k = 8'hff;
        for (int i = 7; i >= 0; i--)
            k = {k[6:0], 1'b0} ^ ((k[7] ^ d[i]) ? 8'h1d : 8'h00);
        return ~k;
    endfunction : crc8
    task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= {3'($random(seed)), sel0};
        wdat <= {24'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            n_mismatch++;
            conclude();
        end
    end
    initial
    begin
        {rst, cyc, stb, we, adr, sel, wdat} = {1'b1, 43'h0};
        seed = 57284;
        sel0 = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wb(0, `VPW_ADDR_CR1, 0);
        check(r, 0);
        wb(0, `VPW_ADDR_CR2, 0);
        check(r, 0);
        wb(0, 4'h2, 0);
        check(r, 0);
        repeat (320) @(posedge clk);
        wb(0, `VPW_ADDR_SVR, 0);
        check(r, 32'h84);
        // write without its low byte lane must leave the enable clear
        sel0 = 1'b0;
        wb(1, `VPW_ADDR_CR1, 1);
        sel0 = 1'b1;
        wb(0, `VPW_ADDR_CR1, 0);
        check(r, 0);
        wb(1, `VPW_ADDR_CR1, 1);
        for (int k = 0; k < 4; k++)
        begin
            b = 8'($random(seed));
            c = crc8(b) ^ 8'(k % 2);
            vpw_node_model_i.send2({b, c});
            repeat (320) @(posedge clk);
            check(irq, 1);
            wb(0, `VPW_ADDR_SVR, 0);
            check(r, (k % 2) ? 32'hcd : 32'hc5);
            wb(0, `VPW_ADDR_DATA, 0);
            check(r, {24'h0, c});
            repeat (2) @(posedge clk);
            check(irq, 0);
        end
        wb(1, `VPW_ADDR_CR1, 0);
        // fast-rate frame: ignored as noise, then taken once enabled
        c = crc8(b);
        vpw_node_model_i.sc = 4;
        for (int f = 0; f < 2; f++)
        begin
            wb(1, `VPW_ADDR_CR2, 8'(2 * f));
            vpw_node_model_i.send2({b, c});
            repeat (320) @(posedge clk);
            wb(0, `VPW_ADDR_SVR, 0);
            check(r, f ? 32'hc5 : 32'h84);
        end
        wb(0, `VPW_ADDR_DATA, 0);
        check(r, {24'h0, c});
        vpw_node_model_i.sc = 1;
        vpw_node_model_i.brk(300);
        repeat (320) @(posedge clk);
        wb(0, `VPW_ADDR_SVR, 0);
        check(r & 32'h10, 32'h10);
        wb(0, `VPW_ADDR_SVR, 0);
        check(r & 32'h10, 0);
        for (int m = 1; m >= 0; m--)
        begin
            b = 8'($random(seed));
            wb(1, `VPW_ADDR_CR2, 8'(m));
            wb(0, `VPW_ADDR_SVR, 0);
            check(r & 32'h4, 32'h4);
            wb(1, `VPW_ADDR_DATA, b);
            repeat (3200) @(posedge clk);
            wb(0, `VPW_ADDR_SVR, 0);
            check(r, 32'hc5);
            wb(0, `VPW_ADDR_DATA, 0);
            check(r, {24'h0, crc8(b)});
        end
        conclude();
    end
endmodule : vpw_protocol_handler_test
`default_nettype wire
